// *** rtl/multimode_16bit_timer.sv ***
/*
  Multimode 16-bit down timer: PWM, event count, capture, difference capture.
  Assumes a byte-wide core bus, a 20 MHz reference clock and a pin pad
  shared with general-purpose line two outside this block.
*/
// Behaviour
// - Outside capture modes, count only while run bit 4 is set; decrement once per counting clock.
// - Reset: counter 0xffff, both reload registers 0x0000, control 0x00.
// - Counting clock is instruction clock or pin edges, by mode.
// - Decrement from 0x0000 is underflow; flag, reload (0xffff in capture modes), toggle pin in PWM with bit 5.
// - Control bit 2 enables the timer interrupt request.
// - Control bit 3 is the pending flag.
// - Interrupt source is underflow, or capture and underflow in capture modes.
// - In capture modes bit 4 becomes the underflow pending flag.
// - Bit 1 picks pulse (opposite edges) or cycle (like edges) capture.
// - PWM bit 0 alternates primary and secondary reload, primary first.
// - Bits 7:6 = 10 select PWM; bit 5 enables pin toggle.
// - Bits 7:6 = 00 count pin edges, bit 5 picks falling.
// - Bits 7:6 = 01 capture count into primary register on chosen edge.
// - Bits 7:6 = 11 difference capture over edge pair chosen by bits 5,1.
// - Counter and reloads are high/low byte pairs; control is one byte.
// - Timer pin is shared with general-purpose line two.
// - PWM and event underflow reloads, continues and sets pending.
// - Interrupt only when enable and global enable are both set.
`timescale 1ns/100ps
`include "timer_map.svh"
module multimode_16bit_timer (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rstn,
  input  wire logic [7:0] i_addr,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_global_irq_enable,
  input  wire logic       i_timer_pin,
  output logic      [7:0] o_rdata,
  output logic            o_timer_interrupt,
  output logic            o_timer_pin,
  output logic            o_timer_pin_oe_n
);
  import timer_pkg::*;

  // =====================================
  // Reset release
  // Asserts at once, leaves on a clock edge after two flops
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // =====================================
  // Instruction clock enable
  // Fixed divide; another reference clock needs a new map value
  logic [4:0] div_cnt;
  logic       instr_tick;
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt    <= 5'h00;
      instr_tick <= 1'b0;
    end else if (div_cnt == 5'((`INSTR_DIV) - 1)) begin
      div_cnt    <= 5'h00;
      instr_tick <= 1'b1;
    end else begin
      div_cnt    <= div_cnt + 5'h01;
      instr_tick <= 1'b0;
    end
  end

  // =====================================
  // Pin edges
  logic pin_rise;
  logic pin_fall;
  // Pin edges assume the source keeps half-rate spacing
  pin_edge_detect u_edge (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (rst_n),
    .i_pin     (i_timer_pin),
    .o_rise    (pin_rise),
    .o_fall    (pin_fall)
  );

  // =====================================
  // Registers and decode
  logic [15:0] timer_count;
  logic [15:0] primary_reload_capture;
  logic [15:0] secondary_reload;
  logic [7:0]  timer_control;
  logic        use_secondary;
  logic        diff_armed;
  logic        pin_level;

  timer_mode_t mode;
  logic        edge_sel;
  logic        run_bit;
  logic        cap_type;

  assign mode     = timer_mode_t'(timer_control[`CTL_MODE_HI:`CTL_MODE_MID]);
  assign edge_sel = timer_control[`CTL_EDGE_TOGGLE];
  assign run_bit  = timer_control[`CTL_RUN_UFPND];
  assign cap_type = timer_control[`CTL_CAPTURE_TYPE];

  function automatic logic wr_at(input logic [7:0] a);
    wr_at = i_wr && (i_addr == a);
  endfunction

  function automatic logic pick_edge(input logic falling, input logic r, input logic f);
    pick_edge = falling ? f : r;
  endfunction

  // =====================================
  // Counting clock selection
  logic capture_mode;
  logic count_tick;
  logic underflow;
  assign capture_mode = (mode == MODE_CAPTURE) || (mode == MODE_DIFF);

  always_comb begin
    unique case (mode)
      MODE_EVENT: count_tick = pick_edge(edge_sel, pin_rise, pin_fall);
      default:    count_tick = instr_tick;
    endcase
  end

  // Capture modes free-run; run bit is reused there
  logic counting;
  assign counting  = count_tick && (capture_mode || run_bit);
  assign underflow = counting && (timer_count == 16'h0000);

  // =====================================
  // Capture events
  logic start_edge;
  logic stop_edge;
  logic capture_now;
  assign start_edge = pick_edge(edge_sel, pin_rise, pin_fall);
  // Like edges when cycle capture, opposite when pulse capture
  assign stop_edge  = pick_edge(edge_sel ^ ~cap_type, pin_rise, pin_fall);

  always_comb begin
    unique case (mode)
      MODE_CAPTURE: capture_now = start_edge;
      MODE_DIFF:    capture_now = diff_armed && stop_edge;
      default:      capture_now = 1'b0;
    endcase
  end

  // Difference capture restarts the counter on the opening edge
  // Cycle capture re-arms on the next like edge, so every other edge measures
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      diff_armed <= 1'b0;
    end else if (mode != MODE_DIFF) begin
      diff_armed <= 1'b0;
    end else if (capture_now) begin
      diff_armed <= 1'b0;
    end else if (start_edge) begin
      diff_armed <= 1'b1;
    end
  end

  // =====================================
  // Counter
  logic [15:0] reload_value;
  always_comb begin
    if (mode == MODE_PWM && timer_control[`CTL_DUAL_RELOAD] && use_secondary) begin
      reload_value = secondary_reload;
    end else begin
      reload_value = primary_reload_capture;
    end
  end

  // No byte latch, so a borrow between two byte writes stays visible
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_count <= `COUNT_RESET;
    end else if (wr_at(`ADDR_COUNT_LO)) begin
      timer_count[7:0] <= i_wdata;
    end else if (wr_at(`ADDR_COUNT_HI)) begin
      timer_count[15:8] <= i_wdata;
    end else if (mode == MODE_DIFF && start_edge && !diff_armed) begin
      timer_count <= `COUNT_RESET;
    end else if (underflow) begin
      if (capture_mode) begin
        timer_count <= `COUNT_RESET;
      end else begin
        timer_count <= reload_value;
      end
    end else if (counting) begin
      timer_count <= timer_count - 16'h0001;
    end
  end

  // Alternation restarts on primary whenever dual reload is off
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      use_secondary <= 1'b0;
    end else if (mode != MODE_PWM || !timer_control[`CTL_DUAL_RELOAD]) begin
      use_secondary <= 1'b0;
    end else if (underflow) begin
      use_secondary <= ~use_secondary;
    end
  end

  // =====================================
  // Reload and capture registers
  logic [15:0] captured;
  assign captured = (mode == MODE_DIFF) ? (`COUNT_RESET - timer_count) : timer_count;

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      primary_reload_capture <= `RELOAD_RESET;
    end else if (capture_now) begin
      // Hardware capture wins over a same-cycle byte write
      primary_reload_capture <= captured;
    end else if (wr_at(`ADDR_RELOAD_A_LO)) begin
      primary_reload_capture[7:0] <= i_wdata;
    end else if (wr_at(`ADDR_RELOAD_A_HI)) begin
      primary_reload_capture[15:8] <= i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      secondary_reload <= `RELOAD_RESET;
    end else if (wr_at(`ADDR_RELOAD_B_LO)) begin
      secondary_reload[7:0] <= i_wdata;
    end else if (wr_at(`ADDR_RELOAD_B_HI)) begin
      secondary_reload[15:8] <= i_wdata;
    end
  end

  // =====================================
  // Control register
  logic set_pending;
  logic set_uf_pending;
  always_comb begin
    unique case (mode)
      MODE_CAPTURE, MODE_DIFF: begin
        set_pending    = capture_now;
        set_uf_pending = underflow;
      end
      default: begin
        set_pending    = underflow;
        set_uf_pending = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_control <= `CONTROL_RESET;
    end else begin
      if (wr_at(`ADDR_CONTROL)) begin
        timer_control <= i_wdata;
      end
      // Hardware set beats a same-cycle clear
      if (set_pending) begin
        timer_control[`CTL_PENDING] <= 1'b1;
      end
      if (set_uf_pending) begin
        timer_control[`CTL_RUN_UFPND] <= 1'b1;
      end
    end
  end

  // =====================================
  // Read data
  logic [7:0] next_rdata;
  always_comb begin
    unique case (i_addr)
      `ADDR_RELOAD_B_LO: next_rdata = secondary_reload[7:0];
      `ADDR_RELOAD_B_HI: next_rdata = secondary_reload[15:8];
      `ADDR_RELOAD_A_LO: next_rdata = primary_reload_capture[7:0];
      `ADDR_RELOAD_A_HI: next_rdata = primary_reload_capture[15:8];
      `ADDR_COUNT_LO:    next_rdata = timer_count[7:0];
      `ADDR_COUNT_HI:    next_rdata = timer_count[15:8];
      `ADDR_CONTROL:     next_rdata = timer_control;
      default:           next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= next_rdata;
    end
  end

  // =====================================
  // Interrupt sources
  // Capture modes keep underflows apart on bit 4, both can interrupt
  logic pending_any;
  always_comb begin
    if (capture_mode) begin
      pending_any = timer_control[`CTL_PENDING] | timer_control[`CTL_RUN_UFPND];
    end else begin
      pending_any = timer_control[`CTL_PENDING];
    end
  end

  // =====================================
  // Interrupt request
  // Registered for a clean request; costs one cycle of latency
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_timer_interrupt <= 1'b0;
    end else begin
      o_timer_interrupt <= pending_any
                         & timer_control[`CTL_IRQ_ENABLE]
                         & i_global_irq_enable;
    end
  end

  // =====================================
  // Timer pin: drives only in PWM, else input for gpio_line_two pad
  // Direction follows mode alone, so a stopped PWM keeps its level
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_level <= 1'b0;
    end else if (mode == MODE_PWM && edge_sel && underflow) begin
      pin_level <= ~pin_level;
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_timer_pin      <= 1'b0;
      o_timer_pin_oe_n <= 1'b1;
    end else begin
      o_timer_pin      <= pin_level;
      o_timer_pin_oe_n <= (mode != MODE_PWM);
    end
  end
endmodule

// *** rtl/timer_map.svh ***
/*
  Offsets, control bit positions, reset values and timing counts of the
  multimode 16-bit timer. Assumes a byte-wide memory-mapped core bus.
*/
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

`define ADDR_RELOAD_B_LO  8'ha7
`define ADDR_RELOAD_B_HI  8'ha8
`define ADDR_RELOAD_A_LO  8'haa
`define ADDR_RELOAD_A_HI  8'hab
`define ADDR_COUNT_LO     8'hac
`define ADDR_COUNT_HI     8'had
`define ADDR_CONTROL      8'hae

`define CTL_MODE_HI       7
`define CTL_MODE_MID      6
`define CTL_EDGE_TOGGLE   5
`define CTL_RUN_UFPND     4
`define CTL_PENDING       3
`define CTL_IRQ_ENABLE    2
`define CTL_CAPTURE_TYPE  1
`define CTL_DUAL_RELOAD   0

`define COUNT_RESET       16'hffff
`define RELOAD_RESET      16'h0000
`define CONTROL_RESET     8'h00

`define REF_CLK_HZ        20000000
`define INSTR_CLK_HZ      1000000
`define INSTR_DIV         (`REF_CLK_HZ / `INSTR_CLK_HZ)

`endif

// *** rtl/timer_pkg.sv ***
/*
  Types of the multimode timer. Assumes timer_map.svh carries the numbers.
*/
package timer_pkg;
  typedef enum logic [1:0] {
    MODE_EVENT   = 2'b00,
    MODE_CAPTURE = 2'b01,
    MODE_DIFF    = 2'b11,
    MODE_PWM     = 2'b10
  } timer_mode_t;
endpackage

// *** rtl/pin_edge_detect.sv ***
/*
  Two-flop synchroniser and edge detector for the timer pin.
  Assumes the pin is asynchronous to i_ref_clk.
*/
`timescale 1ns/100ps
module pin_edge_detect (
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  input  wire logic i_pin,
  output logic      o_rise,
  output logic      o_fall
);
  logic meta;
  logic sync;
  logic prev;

  // =====================================
  // Synchroniser: meta only feeds sync
  // Reset to the pulled-up idle level, so no false edge follows reset
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta <= 1'b1;
      sync <= 1'b1;
      prev <= 1'b1;
    end else begin
      meta <= i_pin;
      sync <= meta;
      prev <= sync;
    end
  end

  assign o_rise = sync & ~prev;
  assign o_fall = ~sync & prev;
endmodule

// *** testbench/multimode_16bit_timer_checker.sv ***
/* Port assertions for the multimode timer.
   Assumes a bind onto multimode_16bit_timer, one clock domain. */
`timescale 1ns/100ps
`include "timer_map.svh"
module multimode_16bit_timer_checker (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rstn,
  input  wire logic [7:0] i_addr,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_global_irq_enable,
  input  wire logic [7:0] o_rdata,
  input  wire logic       o_timer_interrupt,
  input  wire logic       o_timer_pin,
  input  wire logic       o_timer_pin_oe_n
);
  logic ctl_wr;
  assign ctl_wr = i_wr && (i_addr == `ADDR_CONTROL);
  // ==========================================
  // Assertions
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  chk_reset_outs_idle: assert property (
    $rose(i_rstn) |-> o_timer_pin_oe_n && !o_timer_interrupt && o_rdata == 8'h00)
    else $error("outputs not idle after reset");
  chk_rdata_hold: assert property (
    !i_rd |=> $stable(o_rdata)) else $error("read data moved");
  chk_unmapped_zero: assert property (
    i_rd && i_addr == 8'h00 |=> o_rdata == 8'h00) else $error("hole not zero");
  chk_reload_readback: assert property (
    i_wr && i_addr == `ADDR_RELOAD_B_LO ##2 i_rd && i_addr == `ADDR_RELOAD_B_LO
    |=> o_rdata == $past(i_wdata, 3)) else $error("reload byte lost");
  chk_irq_gated: assert property (
    !i_global_irq_enable |=> !o_timer_interrupt) else $error("irq without global");
  chk_irq_holds: assert property (
    o_timer_interrupt && i_global_irq_enable && !$past(i_wr) |=> o_timer_interrupt)
    else $error("irq dropped by itself");
  chk_pin_needs_drive: assert property (
    $changed(o_timer_pin) |-> !$past(o_timer_pin_oe_n)) else $error("pin moved undriven");
  // Direction only follows a control write, one or two edges late
  chk_oe_after_ctl: assert property (
    $changed(o_timer_pin_oe_n) |-> $past(ctl_wr) || $past(ctl_wr, 2))
    else $error("direction changed alone");
endmodule

bind multimode_16bit_timer multimode_16bit_timer_checker u_chk (
  .i_ref_clk, .i_rstn, .i_addr, .i_wr, .i_rd, .i_wdata, .i_global_irq_enable,
  .o_rdata, .o_timer_interrupt, .o_timer_pin, .o_timer_pin_oe_n
);

// *** testbench/timer_pin_source.sv ***
/* Far-side signal source on the timer pin.
   Assumes the bench gates it; it keeps driving its level when stopped. */
`timescale 1ns/100ps
module timer_pin_source #(
  parameter int HALF = 60
) (
  input  wire logic i_ref_clk,
  input  wire logic i_run,
  output logic      o_level
);
  int cnt = 0;
  initial o_level = 1'b1;
  // ==========================================
  // Edges three instruction periods apart, safely slow
  always @(posedge i_ref_clk) begin
    if (i_run) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) o_level <= ~o_level;
    end
  end
endmodule

// *** testbench/multimode_16bit_timer_tb.sv ***
/* Self-checking bench for the multimode timer.
   Assumes a 20 MHz clock and timer_pin_source on the pin. */
`timescale 1ns/100ps
`include "timer_map.svh"
module multimode_16bit_timer_tb;
  localparam int HALF = 60;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        gie = 1'b0;
  logic        src_run = 1'b0;
  logic        src;
  logic        pin;
  logic        pin_d = 1'b1;
  logic [7:0]  rdata;
  logic        irq;
  logic        pin_o;
  logic        oe_n;
  logic [31:0] seed = 32'h9c88;
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          rises = 0;
  int          falls = 0;
  logic [7:0]  amap [8] = '{8'ha7, 8'ha8, 8'haa, 8'hab, 8'hac, 8'had, 8'hae, 8'ha9};
  logic [7:0]  rval [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00};
  logic [7:0]  ctl [8] = '{8'hb0, 8'hb1, 8'h10, 8'h30, 8'hc0, 8'hc2, 8'he0, 8'he2};
  always #25 clk = ~clk;
  // Wired pin: design drives when enabled low, else the source
  assign pin = oe_n ? src : pin_o;
  always @(posedge clk) begin
    pin_d <= pin;
    rises <= rises + int'(pin & ~pin_d);
    falls <= falls + int'(~pin & pin_d);
  end
  multimode_16bit_timer DUT (
    .i_ref_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wr(wr), .i_rd(rd),
    .i_wdata(wdata), .i_global_irq_enable(gie), .i_timer_pin(pin), .o_rdata(rdata),
    .o_timer_interrupt(irq), .o_timer_pin(pin_o), .o_timer_pin_oe_n(oe_n)
  );
  timer_pin_source #(.HALF(HALF)) u_src (.i_ref_clk(clk), .i_run(src_run), .o_level(src));
  // ==========================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int gap(input int r);
    return (r + 1) * `INSTR_DIV;
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_b(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
  // Bounded wait for the next output toggle; n is the gap in clocks
  task automatic wait_tog(output int n);
    logic p;
    p = pin_o;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pin_o === p && n < 5000);
    if (n >= 5000) begin
      cmp(16'h0, 16'h1);
      summarize();
    end
  endtask
  task automatic run_src(input int n);
    src_run <= 1'b1;
    repeat (n) @(posedge clk);
    src_run <= 1'b0;
    repeat (10) @(posedge clk);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    logic [7:0] d;
    logic [7:0] hi;
    int g;
    int a;
    int b;
    int base;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      rd_b(amap[i], d);
      cmp(16'(d), 16'(rval[i]));
    end
    rd_b(8'h00, d);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr_b(amap[i], seed[7:0]);
      rd_b(amap[i], d);
      cmp(16'(d), 16'(seed[7:0]));
    end
    seed = lfsr(seed);
    a = int'(seed[2:0]) + 1;
    b = int'(seed[6:4]) + 2;
    wr_b(8'haa, 8'(a));
    wr_b(8'hab, 8'h00);
    wr_b(8'ha7, 8'(b));
    wr_b(8'ha8, 8'h00);
    wr_b(8'had, 8'h00);
    wr_b(8'hac, 8'h02);
    for (int m = 0; m < 2; m++) begin
      wr_b(8'hae, ctl[m]);
      wait_tog(g);
      for (int k = 0; k < 3; k++) begin
        wait_tog(g);
        cmp(16'(g), 16'(gap((m == 1 && k == 1) ? b : a)));
      end
    end
    cmp(16'(oe_n), 16'h0);
    gie <= 1'b1;
    rd_b(8'hae, d);
    cmp(16'(d[3]), 16'h1);
    wr_b(8'hae, 8'hb5);
    wait_tog(g);
    repeat (3) @(posedge clk);
    cmp(16'(irq), 16'h1);
    gie <= 1'b0;
    repeat (2) @(posedge clk);
    cmp(16'(irq), 16'h0);
    wr_b(8'hae, 8'hb1);
    gie <= 1'b1;
    wait_tog(g);
    repeat (3) @(posedge clk);
    cmp(16'(irq), 16'h0);
    wr_b(8'hae, 8'ha0);
    rd_b(8'hac, d);
    repeat (100) @(posedge clk);
    rd_b(8'hac, hi);
    cmp(16'(hi), 16'(d));
    for (int m = 2; m < 4; m++) begin
      wr_b(8'had, 8'h00);
      wr_b(8'hac, 8'h20);
      base = (m == 3) ? falls : rises;
      wr_b(8'hae, ctl[m]);
      run_src(600);
      g = ((m == 3) ? falls : rises) - base;
      rd_b(8'hac, d);
      cmp(16'(d), 16'(8'h20 - 8'(g)));
      cmp(16'(oe_n), 16'h1);
    end
    for (int m = 4; m < 8; m++) begin
      wr_b(8'hae, ctl[m]);
      run_src(700);
      rd_b(8'haa, d);
      rd_b(8'hab, hi);
      b = (m[0] ? 2 : 1) * HALF / `INSTR_DIV;
      g = int'({hi, d});
      cmp(16'(g >= b - 1 && g <= b + 1), 16'h1);
      rd_b(8'hae, d);
      cmp(16'(d[3]), 16'h1);
    end
    // Single-edge capture on each edge, then a capture-mode underflow
    for (int m = 0; m < 2; m++) begin
      wr_b(8'hae, (m == 1) ? 8'h60 : 8'h40);
      wr_b(8'haa, 8'h00);
      wr_b(8'hab, 8'h00);
      wr_b(8'hac, 8'hff);
      wr_b(8'had, 8'h10);
      run_src(300);
      rd_b(8'haa, d);
      rd_b(8'hab, hi);
      g = int'({hi, d});
      cmp(16'(g > 16'h10e0 && g <= 16'h10ff), 16'h1);
      rd_b(8'hae, d);
      cmp(16'(d[4:3]), 16'h1);
      wr_b(8'had, 8'h00);
      wr_b(8'hac, 8'h00);
      repeat (40) @(posedge clk);
      rd_b(8'hae, d);
      cmp(16'(d[4]), 16'h1);
    end
    summarize();
  end
endmodule
